// ===== common/setup_array_pkg.sv
/*
  constants and types of the channel-setup register array: command codes,
  field positions, reset values, word-rate period table.
  assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none
package setup_array_pkg;
  localparam int          PAIR_COUNT     = 8;
  localparam int          PAIR_WIDTH     = 24;
  localparam int          SETUP_WIDTH    = 12;
  localparam int          IDX_WIDTH      = 3;
  localparam int          BIT_CNT_WIDTH  = 5;
  localparam logic [7:0]  CMD_WRITE_PAIRS = 8'h05;
  localparam logic [7:0]  CMD_READ_PAIRS  = 8'h0d;
  localparam logic [23:0] PAIR_RESET     = 24'h000000;
  localparam logic [3:0]  DEPTH_RESET    = 4'h0;
  localparam logic [4:0]  LAST_BIT       = 5'h17;
  localparam logic [2:0]  LAST_CMD_BIT   = 3'h7;
  // field positions inside one 12-bit setup
  localparam int          LATCH_LSB      = 10;
  localparam int          CHANNEL_LSB    = 7;
  localparam int          RATE_LSB       = 4;
  localparam int          RANGE_LSB      = 1;
  localparam int          POLARITY_BIT   = 0;
  localparam int          PERIOD_WIDTH   = 15;
  // conversion period in master-clock cycles per word-rate code
  localparam logic [14:0] RATE_PERIOD_0  = 15'd2180;
  localparam logic [14:0] RATE_PERIOD_1  = 15'd1092;
  localparam logic [14:0] RATE_PERIOD_2  = 15'd532;
  localparam logic [14:0] RATE_PERIOD_3  = 15'd388;
  localparam logic [14:0] RATE_PERIOD_4  = 15'd324;
  localparam logic [14:0] RATE_PERIOD_5  = 15'd17444;
  localparam logic [14:0] RATE_PERIOD_6  = 15'd8724;
  localparam logic [14:0] RATE_PERIOD_7  = 15'd4364;

  typedef struct packed {
    logic [1:0] latch;
    logic [2:0] channel;
    logic [2:0] rate;
    logic [2:0] range;
    logic       unipolar;
  } setup_type;

  typedef struct packed {
    logic       sclk;
    logic       sdi;
    logic       select_n;
  } serial_in_type;
endpackage
`default_nettype wire

// ===== design/setup_decode.sv
/*
  decodes one 12-bit setup into its channel, range and polarity fields, a range check and its conversion period.
  assumes the caller picks the setup; purely combinational.
*/
`default_nettype none
module setup_decode (
  // setup word
  input  wire logic [11:0] setup_in,
  // decoded fields
  output logic [2:0]  channel_out,
  output logic [2:0]  range_out,
  output logic        unipolar_out,
  output logic        range_valid_out,
  output logic [14:0] period_out
);
  setup_array_pkg::setup_type s;
  assign s               = setup_array_pkg::setup_type'(setup_in);
  assign channel_out     = s.channel;                          // RL11
  assign range_out       = s.range;                            // RL15
  assign range_valid_out = (s.range <= 3'h5);                  // RL15
  assign unipolar_out    = s.unipolar;                         // RL16
  // periods are in master-clock cycles, so rates track the clock
  always_comb begin                                            // RL12 RL13
    case (s.rate)
      3'h0:    period_out = setup_array_pkg::RATE_PERIOD_0;
      3'h1:    period_out = setup_array_pkg::RATE_PERIOD_1;
      3'h2:    period_out = setup_array_pkg::RATE_PERIOD_2;
      3'h3:    period_out = setup_array_pkg::RATE_PERIOD_3;
      3'h4:    period_out = setup_array_pkg::RATE_PERIOD_4;
      3'h5:    period_out = setup_array_pkg::RATE_PERIOD_5;
      3'h6:    period_out = setup_array_pkg::RATE_PERIOD_6;
      default: period_out = setup_array_pkg::RATE_PERIOD_7;
    endcase
  end
endmodule // setup_decode
`default_nettype wire

// ===== design/setup_pair_array.sv
/*
  channel-setup register array behind the serial command port, with depth
  pointer, latch outputs and decode of one selected setup.
  assumes spi-mode-0 style serial pins from outside (synchronised here) and
  a sysclk much faster than the serial clock.
*/
// What this block does
// (RL1) eight 24-bit setup-pair registers
// (RL2) each register holds two 12-bit setups
// (RL3) host sets depth pointer before array access
// (RL4) command 0x05 writes 24 bits per pair
// (RL5) command 0x0d reads 24 bits per pair
// (RL6) depth 0001 one pair, 0011 two pairs
// (RL7) whole 24-bit pairs always transferred
// (RL8) host uses only odd depth values
// (RL9) after last bit, await next command
// (RL10) latch field drives latch pins, reset 00
// (RL11) channel select code picks input channel
// (RL12) word rate code sets conversion period
// (RL13) periods counted in master-clock cycles
// (RL14) reset word rate is 15 sps
// (RL15) range code picks input range
// (RL16) polarity bit: 0 bipolar, 1 unipolar
// (RL17) system reset clears all pairs
// (RL18) depth pointer is four-bit config field
// (RL19) msb first, first pair leading
`default_nettype none
module setup_pair_array (
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // serial command port pins
  input  wire logic        SCLK_IN,
  input  wire logic        SDI_IN,
  input  wire logic        SELECT_N_IN,
  output logic             SDO_OUT,
  output logic             SDO_OE_N_OUT,
  // configuration field from the configuration register
  input  wire logic [3:0]  SETUP_DEPTH_POINTER_IN,
  // setup in use by the conversion sequencer
  input  wire logic [3:0]  ACTIVE_SETUP_IN,
  output logic [1:0]       LATCH_OUTPUT_PINS_OUT,
  output logic [2:0]       INPUT_CHANNEL_SELECT_OUT,
  output logic [2:0]       INPUT_RANGE_SELECT_OUT,
  output logic             UNIPOLAR_OUT,
  output logic             RANGE_VALID_OUT,
  output logic [14:0]      CONVERSION_PERIOD_OUT,
  // port state
  output logic             ARRAY_BUSY_OUT
);
  typedef enum logic [2:0] {
    ST_COMMAND = 3'b001,
    ST_WRITE   = 3'b010,
    ST_READ    = 3'b100
  } state_type;

  // two-stage synchronisers; stage one feeds stage two only
  setup_array_pkg::serial_in_type pins_meta;
  setup_array_pkg::serial_in_type pins_sync;
  logic                           sclk_last;

  state_type                       state;
  state_type                       next_state;
  logic [23:0]                     pair_reg [setup_array_pkg::PAIR_COUNT];   // RL1
  logic [7:0]                      cmd_shift;
  logic [2:0]                      cmd_count;
  logic [23:0]                     data_shift;
  logic [4:0]                      bit_count;
  logic [2:0]                      pair_index;
  logic [2:0]                      last_pair;
  logic                            sdo;
  logic                            sdo_oe_n;

  wire logic        sclk_rise   = pins_sync.sclk & ~sclk_last;
  wire logic        sclk_fall   = ~pins_sync.sclk & sclk_last;
  wire logic        selected    = ~pins_sync.select_n;
  wire logic [7:0]  cmd_next    = {cmd_shift[6:0], pins_sync.sdi};
  wire logic        cmd_done    = selected & sclk_rise
                                  & (cmd_count == setup_array_pkg::LAST_CMD_BIT);
  wire logic        is_write    = cmd_next == setup_array_pkg::CMD_WRITE_PAIRS; // RL4
  wire logic        is_read     = cmd_next == setup_array_pkg::CMD_READ_PAIRS;  // RL5
  wire logic [23:0] word_next   = {data_shift[22:0], pins_sync.sdi};            // RL19
  wire logic        word_done   = selected & sclk_rise
                                  & (bit_count == setup_array_pkg::LAST_BIT);   // RL7
  wire logic        last_word   = pair_index == last_pair;
  // depth counts setups minus one; odd values give whole pairs
  wire logic [2:0]  depth_pairs = SETUP_DEPTH_POINTER_IN[3:1];                  // RL6 RL8 RL18
  wire logic [2:0]  active_pair = ACTIVE_SETUP_IN[3:1];
  wire logic [11:0] active_setup = ACTIVE_SETUP_IN[0] ? pair_reg[active_pair][11:0]
                                                      : pair_reg[active_pair][23:12]; // RL2

  logic [2:0]  dec_channel;
  logic [2:0]  dec_range;
  logic        dec_unipolar;
  logic        dec_range_valid;
  logic [14:0] dec_period;

  setup_decode decode (
    .setup_in        (active_setup),
    .channel_out     (dec_channel),
    .range_out       (dec_range),
    .unipolar_out    (dec_unipolar),
    .range_valid_out (dec_range_valid),
    .period_out      (dec_period)
  );

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pins_meta <= '{sclk: 1'b0, sdi: 1'b0, select_n: 1'b1};
      pins_sync <= '{sclk: 1'b0, sdi: 1'b0, select_n: 1'b1};
      sclk_last <= 1'b0;
    end else begin
      pins_meta <= '{sclk: SCLK_IN, sdi: SDI_IN, select_n: SELECT_N_IN};
      pins_sync <= pins_meta;
      sclk_last <= pins_sync.sclk;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_COMMAND: begin
        if (cmd_done && is_write) begin
          next_state = ST_WRITE;
        end else if (cmd_done && is_read) begin
          next_state = ST_READ;
        end
      end
      ST_WRITE, ST_READ: begin
        if (word_done && last_word) begin
          next_state = ST_COMMAND;                                             // RL9
        end
      end
      default: next_state = ST_COMMAND;
    endcase
  end

  // a deselect abandons any transfer; the host may resynchronise this way
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || !selected) begin
      state <= ST_COMMAND;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || !selected || (state != ST_COMMAND)) begin
      cmd_count <= 3'h0;
    end else if (sclk_rise) begin
      cmd_count <= cmd_count + 3'h1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      cmd_shift <= 8'h00;
    end else if (selected && sclk_rise && state == ST_COMMAND) begin
      cmd_shift <= cmd_next;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || state == ST_COMMAND) begin
      bit_count  <= 5'h00;
      pair_index <= 3'h0;
    end else if (selected && sclk_rise) begin
      bit_count  <= word_done ? 5'h00 : bit_count + 5'h01;
      pair_index <= word_done ? pair_index + 3'h1 : pair_index;              // RL19
    end
  end

  // depth is latched at the command so a mid-transfer change cannot tear it
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      last_pair <= setup_array_pkg::DEPTH_RESET[3:1];
    end else if (cmd_done) begin
      last_pair <= depth_pairs;                                              // RL3 RL6
    end
  end

  // read shifter reloads from the next pair, msb first
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      data_shift <= setup_array_pkg::PAIR_RESET;
    end else if (cmd_done && is_read) begin
      data_shift <= pair_reg[0];                                             // RL5 RL19
    end else if (state == ST_READ && word_done) begin
      data_shift <= pair_reg[pair_index + 3'h1];
    end else if (selected && sclk_rise) begin
      data_shift <= word_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < setup_array_pkg::PAIR_COUNT; g = g + 1) begin : pairs
      always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
          pair_reg[g] <= setup_array_pkg::PAIR_RESET;                        // RL17 RL14 RL10
        end else if (state == ST_WRITE && word_done && pair_index == 3'(g)) begin
          pair_reg[g] <= word_next;                                          // RL4 RL7
        end
      end
    end
  endgenerate

  // the driver stays on for the whole select, command byte included
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= ~selected;
    end
  end

  // sdo changes on the falling edge so the host samples it on the rising one
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sdo <= 1'b0;
    end else if (cmd_done && is_read) begin
      sdo <= pair_reg[0][23];                                                // RL19
    end else if (state == ST_READ && sclk_fall) begin
      sdo <= data_shift[23];
    end else if (state != ST_READ) begin
      sdo <= 1'b0;
    end
  end

  // pin-facing copies: every output leaves straight from a register
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      SDO_OUT <= 1'b0;
    end else begin
      SDO_OUT <= sdo;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      SDO_OE_N_OUT <= 1'b1;
    end else begin
      SDO_OE_N_OUT <= sdo_oe_n;
    end
  end

  // latch pins follow the active setup one clock after it changes
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      LATCH_OUTPUT_PINS_OUT <= 2'b00;
    end else begin
      LATCH_OUTPUT_PINS_OUT <= active_setup[setup_array_pkg::LATCH_LSB +: 2];   // RL10
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      INPUT_CHANNEL_SELECT_OUT <= 3'h0;
    end else begin
      INPUT_CHANNEL_SELECT_OUT <= dec_channel;                               // RL11
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      INPUT_RANGE_SELECT_OUT <= 3'h0;
    end else begin
      INPUT_RANGE_SELECT_OUT <= dec_range;                                   // RL15
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      UNIPOLAR_OUT <= 1'b0;
    end else begin
      UNIPOLAR_OUT <= dec_unipolar;                                          // RL16
    end
  end

  // codes 6 and 7 are flagged, not remapped; the sequencer decides
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      RANGE_VALID_OUT <= 1'b1;
    end else begin
      RANGE_VALID_OUT <= dec_range_valid;                                    // RL15
    end
  end

  // reset value matches the all-zero rate code, the 15 sps setting
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      CONVERSION_PERIOD_OUT <= setup_array_pkg::RATE_PERIOD_0;               // RL14
    end else begin
      CONVERSION_PERIOD_OUT <= dec_period;                                   // RL12 RL13
    end
  end

  // busy marks the data phase only, never the command byte
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ARRAY_BUSY_OUT <= 1'b0;
    end else begin
      ARRAY_BUSY_OUT <= (state != ST_COMMAND);
    end
  end
endmodule // setup_pair_array
`default_nettype wire

// ===== sim/setup_pair_array_sva.sv
/*
  assertions on the ports of the setup array.
  assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module setup_pair_array_sva (
  // clock and reset
  input wire logic        CLOCK_IN,
  input wire logic        RST_IN,
  // watched ports
  input wire logic        SELECT_N_IN,
  input wire logic        SDO_OE_N_OUT,
  input wire logic [3:0]  ACTIVE_SETUP_IN,
  input wire logic [1:0]  LATCH_OUTPUT_PINS_OUT,
  input wire logic [2:0]  INPUT_CHANNEL_SELECT_OUT,
  input wire logic [2:0]  INPUT_RANGE_SELECT_OUT,
  input wire logic        UNIPOLAR_OUT,
  input wire logic        RANGE_VALID_OUT,
  input wire logic [14:0] CONVERSION_PERIOD_OUT,
  input wire logic        ARRAY_BUSY_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  // five cycles cover the select synchroniser
  a_oe_off_idle: assert property (SELECT_N_IN [*5] |-> SDO_OE_N_OUT)
    else $error("sdo driven while deselected");
  a_oe_on_select: assert property (!SELECT_N_IN [*5] |-> !SDO_OE_N_OUT)
    else $error("sdo not driven while selected");
  a_busy_idle: assert property (SELECT_N_IN [*6] |-> !ARRAY_BUSY_OUT)
    else $error("array phase outlives select");
  a_reset_fields: assert property ($fell(RST_IN) |-> LATCH_OUTPUT_PINS_OUT == 2'h0
    && INPUT_CHANNEL_SELECT_OUT == 3'h0 && INPUT_RANGE_SELECT_OUT == 3'h0 && !UNIPOLAR_OUT)
    else $error("decode fields not cleared by reset");
  a_reset_rate: assert property ($fell(RST_IN) |-> CONVERSION_PERIOD_OUT == 15'h0884)
    else $error("reset word rate wrong");
  a_range_valid: assert property (RANGE_VALID_OUT == (INPUT_RANGE_SELECT_OUT <= 3'h5))
    else $error("range valid flag wrong");
  a_period_table: assert property (CONVERSION_PERIOD_OUT inside {15'h0884, 15'h0444,
    15'h0214, 15'h0184, 15'h0144, 15'h4424, 15'h2214, 15'h110c})
    else $error("period outside table");
  a_decode_stable: assert property ((SELECT_N_IN && $stable(ACTIVE_SETUP_IN)) [*4]
    |=> $stable(LATCH_OUTPUT_PINS_OUT) && $stable(INPUT_CHANNEL_SELECT_OUT)
    && $stable(CONVERSION_PERIOD_OUT))
    else $error("decode changed with no cause");
endmodule // setup_pair_array_sva

bind setup_pair_array setup_pair_array_sva chk (.CLOCK_IN, .RST_IN, .SELECT_N_IN,
  .SDO_OE_N_OUT, .ACTIVE_SETUP_IN, .LATCH_OUTPUT_PINS_OUT, .INPUT_CHANNEL_SELECT_OUT,
  .INPUT_RANGE_SELECT_OUT, .UNIPOLAR_OUT, .RANGE_VALID_OUT, .CONVERSION_PERIOD_OUT,
  .ARRAY_BUSY_OUT);
`default_nettype wire

// ===== sim/serial_host.sv
/*
  host controller model on the serial command port.
  assumes the bench clock; changes pins on its falling edge.
*/
`default_nettype none
module serial_host (
  // bench clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      sdi,
  output logic      select_n,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    select_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // n bits msb first, command byte leading; a short n is an abort
  task automatic frame(input logic [199:0] tx, input int n, output logic [199:0] rx);
    rx = '0;
    select_n = 1'b0;
    hold(6);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      hold(6);
      rx[i] = sdo_oe_n ? 1'bx : sdo;
      sclk = 1'b1;
      hold(6);
      sclk = 1'b0;
    end
    hold(6);
    select_n = 1'b1;
    // idle data line must not look like the last bit
    sdi = ~sdi;
    hold(12);
  endtask
endmodule // serial_host
`default_nettype wire

// ===== sim/tb_top.sv
/*
  bench for the setup array: host model on the serial port, depth
  pointer and active setup driven here. assumes the bound checker.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         sclk, sdi, sel_n, sdo, oe_n, uni, rvalid, busy;
  logic [3:0]   depth = 4'h0;
  logic [3:0]   active = 4'h0;
  logic [1:0]   latch;
  logic [2:0]   chan, rng;
  logic [14:0]  period;
  logic [24:0]  dec, e;
  logic [191:0] w, pat, got;
  logic [11:0]  s;
  int           failures = 0;
  int           num_checks = 0;
  int           busy_cycles = 0;
  int           busy_len = 0;
  localparam logic [14:0] PERIODS [8] = '{15'h0884, 15'h0444, 15'h0214, 15'h0184,
    15'h0144, 15'h4424, 15'h2214, 15'h110c};
  assign dec = {latch, chan, rng, uni, rvalid, period};
  always #2.5 clk = ~clk;
  // running count of busy clocks; xfer takes the share of its own frame
  always @(posedge clk) busy_cycles <= busy_cycles + int'(busy);
  setup_pair_array dut (.CLOCK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .SDI_IN(sdi),
    .SELECT_N_IN(sel_n), .SDO_OUT(sdo), .SDO_OE_N_OUT(oe_n), .SETUP_DEPTH_POINTER_IN(depth),
    .ACTIVE_SETUP_IN(active), .LATCH_OUTPUT_PINS_OUT(latch), .INPUT_CHANNEL_SELECT_OUT(chan),
    .INPUT_RANGE_SELECT_OUT(rng), .UNIPOLAR_OUT(uni), .RANGE_VALID_OUT(rvalid),
    .CONVERSION_PERIOD_OUT(period), .ARRAY_BUSY_OUT(busy));
  serial_host h (.clk(clk), .sclk(sclk), .sdi(sdi), .select_n(sel_n), .sdo(sdo),
    .sdo_oe_n(oe_n));
  task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [3:0] dp, input logic [191:0] data,
                      input int n);
    logic [199:0] rx;
    int           b0;
    depth = dp;
    @(negedge clk);
    b0 = busy_cycles;
    h.frame((200'(cmd) << n) | 200'(data), n + 8, rx);
    got = rx[191:0] & ((192'h1 << n) - 192'h1);
    busy_len = busy_cycles - b0;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("reset decode", dec, {9'h000, 1'b1, 15'h0884});
    xfer(8'h0d, 4'h1, '0, 24);
    check("reset pair", got, '0);
    $display("test reset done");
    w = 192'hc5a3e1_3b7d96;
    xfer(8'h05, 4'h3, w, 48);
    xfer(8'h0d, 4'h3, '0, 48);
    check("two pairs", got, w);
    xfer(8'h0d, 4'h1, '0, 24);
    check("first pair", got, w >> 24);
    // the host model spends 12 clocks per bit; busy spans the 24 data bits
    check("read busy clocks", busy_len, 24 * 12);
    xfer(8'h45, 4'h1, 192'hffffff, 24);
    check("refused busy", busy_len, '0);
    xfer(8'h0d, 4'h1, '0, 24);
    check("refused command", got, w >> 24);
    xfer(8'h05, 4'h3, 192'h123456_abc, 36);
    xfer(8'h0d, 4'h3, '0, 48);
    check("aborted write", got, 192'({24'h123456, w[23:0]}));
    // write then read in one select: the port must be back in command mode
    xfer(8'h05, 4'h1, 192'({24'h5a0f3c, 8'h0d, 24'h000000}), 56);
    check("command after pair", got, 192'h5a0f3c);
    $display("test depth done");
    for (int k = 0; k < 16; k++)
      pat[191 - 12 * k -: 12] = {k[1:0], k[2:0], k[2:0] ^ 3'h5, 3'(k + 3), k[0]};
    xfer(8'h05, 4'hf, pat, 192);
    xfer(8'h0d, 4'hf, '0, 192);
    check("eight pairs", got, pat);
    for (int k = 0; k < 16; k++) begin
      active = 4'(k);
      repeat (4) @(negedge clk);
      s = pat[191 - 12 * k -: 12];
      e = {s[11:7], s[3:0], (s[3:1] <= 3'h5), PERIODS[s[6:4]]};
      check("decode", dec, e);
    end
    $display("test decode done");
    // reset in mid-run must clear every pair written above
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("reset again decode", dec, {9'h000, 1'b1, 15'h0884});
    xfer(8'h0d, 4'hf, '0, 192);
    check("pairs cleared", got, '0);
    $display("test second reset done");
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
